/* File: hw/hole_decoder_pkg.sv */
// package: register map, field positions and carriers for the address hole decoder
package hole_decoder_pkg;

    // =====================================================================
    // register indices
    localparam logic [7:0] IDX_ROM_CFG = 8'h07;
    localparam logic [7:0] IDX_HOLE_EN = 8'h08;
    localparam logic [7:0] IDX_IOA_START = 8'h10;
    localparam logic [7:0] IDX_IOA_END = 8'h11;
    localparam logic [7:0] IDX_IOB_START = 8'h12;
    localparam logic [7:0] IDX_IOB_END = 8'h13;
    localparam logic [7:0] IDX_MEMA_LOW = 8'h16;
    localparam logic [7:0] IDX_MEMA_HIGH = 8'h17;
    localparam logic [7:0] IDX_MEMB_START_LOW = 8'h19;
    localparam logic [7:0] IDX_MEMB_START_HIGH = 8'h1a;
    localparam logic [7:0] IDX_MEMB_END_LOW = 8'h1c;
    localparam logic [7:0] IDX_MEMB_END_HIGH = 8'h1d;
    localparam logic [7:0] IDX_ROM_STATUS = 8'h20;

    // =====================================================================
    // reset values
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // =====================================================================
    // field positions
    localparam int ROM_VIDEO_SHARED_BIT = 1;
    localparam int ROM_SIZE_128K_BIT = 2;
    localparam int ROM_MIDDLE_EN_BIT = 3;
    localparam int EN_MEM_A_BIT = 0;
    localparam int EN_MEM_B_BIT = 1;
    localparam int EN_IO_A_BIT = 3;
    localparam int EN_IO_B_BIT = 4;
    localparam logic [7:0] ROM_CFG_WRITE_MASK = 8'h0f;
    localparam logic [7:0] HOLE_EN_WRITE_MASK = 8'h1b;
    localparam logic [7:0] UPPER_WRITE_MASK = 8'h3f;

    // =====================================================================
    // address slices
    localparam int IO_BLOCK_LSB = 4;
    localparam int IO_BLOCK_MSB = 11;
    localparam int MEM_BLOCK_LSB = 14;
    localparam int MEM_BLOCK_MSB = 27;
    localparam int ADDR_W = 32;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic is_io;
        logic [ADDR_W-1:0] addr;
    } bus_cycle_t;

    typedef struct packed {
        logic video_shared;
        logic size_128k;
        logic middle_en;
        logic rom_8bit;
    } rom_cfg_t;

endpackage : hole_decoder_pkg

/* File: hw/range_match.sv */
// file: half-open range comparator used for each variable window
`timescale 1ns/1ns
`default_nettype none
module range_match #(
    parameter int W = 8
) (
    input wire logic [W-1:0] value_in,
    input wire logic [W-1:0] start_in,
    input wire logic [W-1:0] end_in,
    input wire logic enable_in,
    output logic hit_out
);
    // start <= value < end; an empty or inverted range never matches
    assign hit_out = enable_in && (end_in > start_in) && (value_in >= start_in)
        && (value_in < end_in); // R18
endmodule : range_match
`default_nettype wire

/* File: hw/address_hole_decoder.sv */
// file: configuration registers and hole comparators for the default local-bus responder
// Functional notes
// [R01] rom config bits select shared video bios and 64k or 128k rom size
// [R02] rom config bit enables decode of the 64k middle bios region
// [R03] rom width strap sampled at reset; high means 8-bit, low 16-bit
// [R04] default responder claims cycles no local device claims, unless in a hole
// [R05] inside an enabled hole the device neither starts nor ends the cycle
// [R06] two io holes and two memory holes, each with registers and enable
// [R07] io holes use 16-byte blocks from address bits 11 to 4
// [R08] software loads io end register with last block plus one
// [R09] software programs range registers before setting the enable
// [R10] memory hole a is a fixed 16k window at bits 27 to 14
// [R11] memory hole b spans start to end minus one in 16k blocks
// [R12] enable bits: 0 mem a, 1 mem b, 3 io a, 4 io b
// [R13] upper memory registers keep six bits; bits 7:6 reserved
// [R14] software writes zero to reserved bits
// [R15] hole registers and enable reset to zero so no hole is active
// [R16] rom config resets to zero and is read-write
// [R17] io holes match io cycles only, memory holes memory cycles only
// [R18] an end not above start matches nothing
`timescale 1ns/1ns
`default_nettype none
module address_hole_decoder (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic cycle_valid_in,
    input wire logic cycle_is_io_in,
    input wire logic [31:0] cycle_addr_in,
    input wire logic local_device_claim_in,
    input wire logic rom_width_strap_in,
    output logic claim_out,
    output logic in_hole_out,
    output logic rom_video_shared_out,
    output logic rom_size_128k_out,
    output logic rom_middle_en_out,
    output logic rom_8bit_out
);

    // =====================================================================
    // carriers
    hole_decoder_pkg::reg_req_t req;
    hole_decoder_pkg::bus_cycle_t cyc;
    hole_decoder_pkg::rom_cfg_t rom_cfg;
    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
    assign cyc = '{valid: cycle_valid_in, is_io: cycle_is_io_in, addr: cycle_addr_in};

    // =====================================================================
    // register storage
    logic [7:0] rom_cfg_q;
    logic [7:0] hole_en_q;
    logic [7:0] io_start_q [2];
    logic [7:0] io_end_q [2];
    logic [7:0] mema_low_q;
    logic [5:0] mema_high_q;
    logic [7:0] membs_low_q;
    logic [5:0] membs_high_q;
    logic [7:0] membe_low_q;
    logic [5:0] membe_high_q;
    logic rom_8bit_q;
    logic strap_taken_q;
    logic [7:0] rdata_q;

    // rom configuration, reserved bits held at zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rom_cfg_q <= hole_decoder_pkg::RESET_VALUE; // R16
        end else if (req.wr && req.addr == hole_decoder_pkg::IDX_ROM_CFG) begin
            rom_cfg_q <= req.wdata & hole_decoder_pkg::ROM_CFG_WRITE_MASK; // R16
        end
    end

    // hole enables, reserved bits held at zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hole_en_q <= hole_decoder_pkg::RESET_VALUE; // R15
        end else if (req.wr && req.addr == hole_decoder_pkg::IDX_HOLE_EN) begin
            hole_en_q <= req.wdata & hole_decoder_pkg::HOLE_EN_WRITE_MASK; // R12
        end
    end

    // io window bounds, pairs at consecutive indices
    generate
        for (genvar i = 0; i < 2; i++) begin : g_io_regs
            localparam logic [7:0] START_IDX = hole_decoder_pkg::IDX_IOA_START + 8'(2 * i);
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    io_start_q[i] <= hole_decoder_pkg::RESET_VALUE; // R15
                    io_end_q[i] <= hole_decoder_pkg::RESET_VALUE;
                end else if (req.wr && req.addr == START_IDX) begin
                    io_start_q[i] <= req.wdata; // R07
                end else if (req.wr && req.addr == START_IDX + 8'h01) begin
                    io_end_q[i] <= req.wdata; // R07
                end
            end
        end
    endgenerate

    // memory window bounds; upper halves keep six bits
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mema_low_q <= hole_decoder_pkg::RESET_VALUE; // R15
            mema_high_q <= 6'h00;
            membs_low_q <= hole_decoder_pkg::RESET_VALUE;
            membs_high_q <= 6'h00;
            membe_low_q <= hole_decoder_pkg::RESET_VALUE;
            membe_high_q <= 6'h00;
        end else if (req.wr) begin
            case (req.addr)
                hole_decoder_pkg::IDX_MEMA_LOW: begin
                    mema_low_q <= req.wdata;
                end
                hole_decoder_pkg::IDX_MEMA_HIGH: begin
                    mema_high_q <= req.wdata[5:0]; // R13
                end
                hole_decoder_pkg::IDX_MEMB_START_LOW: begin
                    membs_low_q <= req.wdata;
                end
                hole_decoder_pkg::IDX_MEMB_START_HIGH: begin
                    membs_high_q <= req.wdata[5:0]; // R13
                end
                hole_decoder_pkg::IDX_MEMB_END_LOW: begin
                    membe_low_q <= req.wdata;
                end
                hole_decoder_pkg::IDX_MEMB_END_HIGH: begin
                    membe_high_q <= req.wdata[5:0]; // R13
                end
                default: begin
                end
            endcase
        end
    end

    // strap caught on the first clock after reset release
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            strap_taken_q <= 1'b0;
            rom_8bit_q <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            rom_8bit_q <= rom_width_strap_in; // R03
        end
    end

    // =====================================================================
    // read port, data valid the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                hole_decoder_pkg::IDX_ROM_CFG: rdata_q <= rom_cfg_q;
                hole_decoder_pkg::IDX_HOLE_EN: rdata_q <= hole_en_q;
                hole_decoder_pkg::IDX_IOA_START: rdata_q <= io_start_q[0];
                hole_decoder_pkg::IDX_IOA_END: rdata_q <= io_end_q[0];
                hole_decoder_pkg::IDX_IOB_START: rdata_q <= io_start_q[1];
                hole_decoder_pkg::IDX_IOB_END: rdata_q <= io_end_q[1];
                hole_decoder_pkg::IDX_MEMA_LOW: rdata_q <= mema_low_q;
                hole_decoder_pkg::IDX_MEMA_HIGH: rdata_q <= {2'b00, mema_high_q};
                hole_decoder_pkg::IDX_MEMB_START_LOW: rdata_q <= membs_low_q;
                hole_decoder_pkg::IDX_MEMB_START_HIGH: rdata_q <= {2'b00, membs_high_q};
                hole_decoder_pkg::IDX_MEMB_END_LOW: rdata_q <= membe_low_q;
                hole_decoder_pkg::IDX_MEMB_END_HIGH: rdata_q <= {2'b00, membe_high_q};
                hole_decoder_pkg::IDX_ROM_STATUS: rdata_q <= {7'h00, rom_8bit_q};
                default: rdata_q <= 8'h00; // unmapped reads zero
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata_out = rdata_q;

    // =====================================================================
    // hole comparators
    logic [7:0] io_block;
    logic [13:0] mem_block;
    logic [13:0] mema_base;
    logic [13:0] membs;
    logic [13:0] membe;
    logic io_hit [2];
    logic mem_a_hit;
    logic mem_b_hit;
    logic hole_hit;

    assign io_block = cyc.addr[hole_decoder_pkg::IO_BLOCK_MSB:hole_decoder_pkg::IO_BLOCK_LSB];
    assign mem_block = cyc.addr[hole_decoder_pkg::MEM_BLOCK_MSB:hole_decoder_pkg::MEM_BLOCK_LSB];
    assign mema_base = {mema_high_q, mema_low_q}; // R10
    assign membs = {membs_high_q, membs_low_q};
    assign membe = {membe_high_q, membe_low_q};

    // io windows, one comparator each
    generate
        for (genvar j = 0; j < 2; j++) begin : g_io_match
            localparam int EN_BIT = (j == 0) ? hole_decoder_pkg::EN_IO_A_BIT
                : hole_decoder_pkg::EN_IO_B_BIT;
            range_match #(.W(8)) u_io (
                .value_in(io_block),
                .start_in(io_start_q[j]),
                .end_in(io_end_q[j]),
                .enable_in(hole_en_q[EN_BIT] && cyc.is_io), // R17
                .hit_out(io_hit[j])
            );
        end
    endgenerate

    // memory window b, arbitrary length
    range_match #(.W(14)) u_mem_b (
        .value_in(mem_block),
        .start_in(membs),
        .end_in(membe),
        .enable_in(hole_en_q[hole_decoder_pkg::EN_MEM_B_BIT] && !cyc.is_io), // R11
        .hit_out(mem_b_hit)
    );

    // memory window a, single 16k block
    assign mem_a_hit = hole_en_q[hole_decoder_pkg::EN_MEM_A_BIT] && !cyc.is_io
        && (mem_block == mema_base); // R10

    assign hole_hit = io_hit[0] || io_hit[1] || mem_a_hit || mem_b_hit; // R06

    // default responder: claim unless a local device or a hole owns the cycle
    assign claim_out = cyc.valid && !local_device_claim_in && !hole_hit; // R04 R05
    assign in_hole_out = cyc.valid && hole_hit; // R05

    // rom configuration outputs
    assign rom_cfg = '{video_shared: rom_cfg_q[hole_decoder_pkg::ROM_VIDEO_SHARED_BIT],
        size_128k: rom_cfg_q[hole_decoder_pkg::ROM_SIZE_128K_BIT],
        middle_en: rom_cfg_q[hole_decoder_pkg::ROM_MIDDLE_EN_BIT],
        rom_8bit: rom_8bit_q};
    assign rom_video_shared_out = rom_cfg.video_shared; // R01
    assign rom_size_128k_out = rom_cfg.size_128k; // R01
    assign rom_middle_en_out = rom_cfg.middle_en; // R02
    assign rom_8bit_out = rom_cfg.rom_8bit; // R03

    // =====================================================================
    // assertions
    property p_no_claim_in_hole;
        @(posedge clk_in) disable iff (rst_in) in_hole_out |-> !claim_out;
    endproperty
    a_no_claim_in_hole: assert property (p_no_claim_in_hole) else $error("claim in hole"); // R05

    property p_default_claim;
        @(posedge clk_in) disable iff (rst_in)
            (cycle_valid_in && !local_device_claim_in && hole_en_q == 8'h00) |-> claim_out;
    endproperty
    a_default_claim: assert property (p_default_claim) else $error("default not claimed"); // R04

    property p_local_wins;
        @(posedge clk_in) disable iff (rst_in) local_device_claim_in |-> !claim_out;
    endproperty
    a_local_wins: assert property (p_local_wins) else $error("claimed local cycle"); // R04

    property p_io_only_io;
        @(posedge clk_in) disable iff (rst_in)
            (!cycle_is_io_in) |-> !(io_hit[0] || io_hit[1]);
    endproperty
    a_io_only_io: assert property (p_io_only_io) else $error("io hole on mem cycle"); // R17

    property p_mem_only_mem;
        @(posedge clk_in) disable iff (rst_in) cycle_is_io_in |-> !(mem_a_hit || mem_b_hit);
    endproperty
    a_mem_only_mem: assert property (p_mem_only_mem) else $error("mem hole on io cycle"); // R17

    property p_empty_range;
        @(posedge clk_in) disable iff (rst_in) (membe <= membs) |-> !mem_b_hit;
    endproperty
    a_empty_range: assert property (p_empty_range) else $error("empty range matched"); // R18

    property p_reserved_zero;
        @(posedge clk_in) disable iff (rst_in)
            (rom_cfg_q[7:4] == 4'h0) && (hole_en_q[2] == 1'b0) && (hole_en_q[7:5] == 3'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // R13

    property p_write_read;
        @(posedge clk_in) disable iff (rst_in)
            (reg_wr_in && reg_addr_in == hole_decoder_pkg::IDX_IOA_START) ##1
            (reg_rd_in && reg_addr_in == hole_decoder_pkg::IDX_IOA_START && !reg_wr_in)
            |=> (reg_rdata_out == $past(reg_wdata_in, 2));
    endproperty
    a_write_read: assert property (p_write_read) else $error("readback mismatch"); // R07

    property p_reset_clear;
        @(posedge clk_in) rst_in |=> (hole_en_q == 8'h00 && rom_cfg_q == 8'h00);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset value wrong"); // R15

    property p_strap_hold;
        @(posedge clk_in) disable iff (rst_in) strap_taken_q |=> $stable(rom_8bit_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed"); // R03

    property p_strap_capture;
        @(posedge clk_in) disable iff (rst_in)
            !strap_taken_q |=> (rom_8bit_out == $past(rom_width_strap_in));
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("strap not captured"); // R03

    property p_rdata_idle;
        @(posedge clk_in) disable iff (rst_in) !reg_rd_in |=> (reg_rdata_out == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared"); // R16

    property p_rom_cfg_write;
        @(posedge clk_in) disable iff (rst_in)
            (reg_wr_in && reg_addr_in == hole_decoder_pkg::IDX_ROM_CFG)
            |=> (rom_cfg_q == ($past(reg_wdata_in) & 8'h0f));
    endproperty
    a_rom_cfg_write: assert property (p_rom_cfg_write) else $error("rom config lost"); // R16

    property p_io_a_hole;
        @(posedge clk_in) disable iff (rst_in)
            (cycle_valid_in && cycle_is_io_in && hole_en_q[hole_decoder_pkg::EN_IO_A_BIT]
            && cycle_addr_in[11:4] >= io_start_q[0] && cycle_addr_in[11:4] < io_end_q[0])
            |-> (in_hole_out && !claim_out);
    endproperty
    a_io_a_hole: assert property (p_io_a_hole) else $error("io hole a not honoured"); // R07

    property p_io_b_hole;
        @(posedge clk_in) disable iff (rst_in)
            (cycle_valid_in && cycle_is_io_in && hole_en_q[hole_decoder_pkg::EN_IO_B_BIT]
            && cycle_addr_in[11:4] >= io_start_q[1] && cycle_addr_in[11:4] < io_end_q[1])
            |-> (in_hole_out && !claim_out);
    endproperty
    a_io_b_hole: assert property (p_io_b_hole) else $error("io hole b not honoured"); // R06

    property p_mem_a_hole;
        @(posedge clk_in) disable iff (rst_in)
            (cycle_valid_in && !cycle_is_io_in && hole_en_q[hole_decoder_pkg::EN_MEM_A_BIT]
            && cycle_addr_in[27:14] == {mema_high_q, mema_low_q})
            |-> (in_hole_out && !claim_out);
    endproperty
    a_mem_a_hole: assert property (p_mem_a_hole) else $error("mem hole a not honoured"); // R10

    property p_mem_b_hole;
        @(posedge clk_in) disable iff (rst_in)
            (cycle_valid_in && !cycle_is_io_in && hole_en_q[hole_decoder_pkg::EN_MEM_B_BIT]
            && cycle_addr_in[27:14] >= membs && cycle_addr_in[27:14] < membe)
            |-> (in_hole_out && !claim_out);
    endproperty
    a_mem_b_hole: assert property (p_mem_b_hole) else $error("mem hole b not honoured"); // R11

    property p_idle_quiet;
        @(posedge clk_in) disable iff (rst_in) !cycle_valid_in |-> !(claim_out || in_hole_out);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("output without cycle"); // R04

    c_claim: cover property (@(posedge clk_in) disable iff (rst_in) claim_out);
    c_io_hole: cover property (@(posedge clk_in) disable iff (rst_in) io_hit[0] || io_hit[1]);
    c_mem_a: cover property (@(posedge clk_in) disable iff (rst_in) mem_a_hit);
    c_mem_b: cover property (@(posedge clk_in) disable iff (rst_in) mem_b_hit);
    c_empty_b: cover property (@(posedge clk_in) disable iff (rst_in)
        hole_en_q[hole_decoder_pkg::EN_MEM_B_BIT] && (membe <= membs));

endmodule : address_hole_decoder
`default_nettype wire

/* File: test/local_bus_model.sv */
// partner: local bus master and the other local-bus devices
`timescale 1ns/1ns
`default_nettype none
module local_bus_model (
    input wire logic clk_in,
    output logic cycle_valid_out,
    output logic cycle_is_io_out,
    output logic [31:0] cycle_addr_out,
    output logic local_device_claim_out
);
    // =====================================================================
    // bus idle at time zero
    initial begin
        cycle_valid_out = 1'b0;
        cycle_is_io_out = 1'b0;
        cycle_addr_out = 32'h0000_0000;
        local_device_claim_out = 1'b0;
    end

    // =====================================================================
    // one cycle after gap idle cycles; released lines show the inverse, not the old value
    task automatic run_cycle(input logic is_io, input logic [31:0] addr, input logic claim,
            input int gap);
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        cycle_valid_out <= 1'b1;
        cycle_is_io_out <= is_io;
        cycle_addr_out <= addr;
        local_device_claim_out <= claim;
        @(posedge clk_in);
        cycle_valid_out <= 1'b0;
        cycle_is_io_out <= ~is_io;
        cycle_addr_out <= ~addr;
        local_device_claim_out <= ~claim;
    endtask : run_cycle
endmodule : local_bus_model
`default_nettype wire

/* File: test/tb_top.sv */
// testbench: registers, strap capture and hole decoding of the address hole decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk_in;
    logic rst_in;
    logic [7:0] ra;
    logic [7:0] rwd;
    logic rwr;
    logic rrd;
    logic [7:0] rdat;
    logic cv;
    logic cio;
    logic [31:0] cad;
    logic lcl;
    logic strap;
    logic claim;
    logic hole;
    logic [3:0] rom;
    int errors;
    int checks_done;
    logic rd_seen;
    logic [7:0] rd_q[$];
    logic [1:0] bus_q[$];
    logic [7:0] idx [12] = '{8'h07, 8'h08, 8'h10, 8'h11, 8'h12, 8'h13, 8'h16, 8'h17,
        8'h19, 8'h1a, 8'h1c, 8'h1d};
    logic [31:0] probe [13] = '{32'h31f, 32'h320, 32'h32f, 32'h330, 32'h41f, 32'h420,
        32'h14d0000, 32'h14cc000, 32'h14d4000, 32'h3fc000, 32'h400000, 32'h408000, 32'h40c000};
    logic [7:0] ens [6] = '{8'h00, 8'h08, 8'h10, 8'h01, 8'h02, 8'h1b};

    // =====================================================================
    // design and far side
    address_hole_decoder uut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(ra),
        .reg_wdata_in(rwd), .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rdat),
        .cycle_valid_in(cv), .cycle_is_io_in(cio), .cycle_addr_in(cad),
        .local_device_claim_in(lcl), .rom_width_strap_in(strap), .claim_out(claim),
        .in_hole_out(hole), .rom_video_shared_out(rom[0]), .rom_size_128k_out(rom[1]),
        .rom_middle_en_out(rom[2]), .rom_8bit_out(rom[3]));
    local_bus_model lbm (.clk_in(clk_in), .cycle_valid_out(cv), .cycle_is_io_out(cio),
        .cycle_addr_out(cad), .local_device_claim_out(lcl));

    // =====================================================================
    // clock and time-zero inputs
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        rst_in = 1'b1;
        strap = 1'b1;
        ra = 8'h00;
        rwd = 8'h00;
        rwr = 1'b0;
        rrd = 1'b0;
        rd_seen = 1'b0;
        errors = 0;
        checks_done = 0;
    end

    // =====================================================================
    // helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        ra <= a;
        rwd <= d;
        rwr <= 1'b1;
        rrd <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        @(posedge clk_in);
        ra <= a;
        rwr <= 1'b0;
        rrd <= 1'b1;
    endtask : rd
    task automatic idle();
        @(posedge clk_in);
        rwr <= 1'b0;
        rrd <= 1'b0;
    endtask : idle
    task automatic bus(input logic io, input logic [31:0] a, input logic lc, input logic h);
        bus_q.push_back({~lc & ~h, h});
        lbm.run_cycle(io, a, lc, $urandom_range(2));
    endtask : bus
    task automatic do_reset(input logic s);
        @(posedge clk_in);
        rst_in <= 1'b1;
        strap <= s;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        strap <= ~s;
        #1 check({7'h0, rom[3]}, {7'h0, s});
    endtask : do_reset
    function automatic logic [7:0] msk(input logic [7:0] a);
        msk = 8'hff;
        if (a == 8'h07) msk = 8'h0f;
        if (a == 8'h08) msk = 8'h1b;
        if (a == 8'h17 || a == 8'h1a || a == 8'h1d) msk = 8'h3f;
    endfunction : msk
    // reference decode of the windows programmed below
    function automatic logic hole_of(input logic io, input logic [31:0] a, input logic [7:0] en);
        logic [13:0] b;
        b = a[27:14];
        if (io) hole_of = (en[3] && a[11:4] >= 8'h32 && a[11:4] < 8'h33)
            || (en[4] && a[11:4] >= 8'h40 && a[11:4] < 8'h42);
        else hole_of = (en[0] && b == 14'h0534) || (en[1] && b >= 14'h0100 && b < 14'h0103);
    endfunction : hole_of

    // =====================================================================
    // monitor: read data one cycle after the strobe, claim and hole per bus cycle
    always @(posedge clk_in) begin
        if (rd_seen) check(rdat, rd_q.pop_front());
        rd_seen = rrd;
        check({6'h0, claim, hole}, cv ? {6'h0, bus_q.pop_front()} : 8'h00);
    end

    // =====================================================================
    // watchdog
    initial begin
        #(40 * 20000);
        errors++;
        end_sim();
    end

    // =====================================================================
    // main sequence
    initial begin
        logic [7:0] d;
        logic [31:0] a;
        void'($urandom(32'h27b8));
        do_reset(1'b1);
        foreach (idx[i]) rd(idx[i], 8'h00);
        rd(8'h20, 8'h01);
        foreach (idx[i]) begin
            d = 8'($urandom);
            wr(idx[i], d);
            rd(idx[i], d & msk(idx[i]));
        end
        wr(8'h09, 8'hff);
        wr(8'h20, 8'hfe);
        rd(8'h09, 8'h00);
        rd(8'h20, 8'h01);
        // rom config bits drive the rom outputs
        for (int v = 0; v < 16; v++) begin
            wr(8'h07, 8'(v));
            idle();
            #1 check({4'h0, rom}, 8'(8 | (v >> 1)));
        end
        // ranges first, enables after
        wr(8'h10, 8'h32);
        wr(8'h11, 8'h33);
        wr(8'h12, 8'h40);
        wr(8'h13, 8'h42);
        wr(8'h16, 8'h34);
        wr(8'h17, 8'h05);
        wr(8'h19, 8'h00);
        wr(8'h1a, 8'h01);
        wr(8'h1c, 8'h03);
        wr(8'h1d, 8'h01);
        foreach (ens[e]) begin
            wr(8'h08, ens[e]);
            idle();
            foreach (probe[p]) begin
                a = probe[p] | ((probe[p] > 32'hffff) ? 32'($urandom_range(16383)) : 32'h0);
                for (int io = 0; io < 2; io++) begin
                    d = {7'h0, hole_of(1'(io), a, ens[e])};
                    bus(1'(io), a, 1'($urandom_range(1)), d[0]);
                end
            end
        end
        // end not above start matches nothing
        wr(8'h13, 8'h40);
        wr(8'h1d, 8'h00);
        wr(8'h08, 8'h12);
        idle();
        bus(1'b1, 32'h400, 1'b0, 1'b0);
        bus(1'b0, 32'h400000, 1'b0, 1'b0);
        // second reset clears holes and recaptures the strap
        wr(8'h08, 8'h1b);
        idle();
        do_reset(1'b0);
        bus(1'b1, 32'h320, 1'b0, 1'b0);
        rd(8'h20, 8'h00);
        foreach (idx[i]) rd(idx[i], 8'h00);
        idle();
        repeat (4) @(posedge clk_in);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
